// File: inc/aoc_pkg.sv
// shared constants and types of the analog output control block
package aoc_pkg;

  // channel layout
  localparam int unsigned AOC_NUM_CH = 4;
  localparam int unsigned AOC_CODE_W = 12;

  // register indices, byte address is four times the index
  localparam logic [3:0] AOC_IDX_CODE0 = 4'h0;
  localparam logic [3:0] AOC_IDX_CODE3 = 4'h3;
  localparam logic [3:0] AOC_IDX_FLAGS = 4'hC;
  localparam logic [3:0] AOC_IDX_CFG = 4'hD;

  // bus encodings
  localparam logic [2:0] AOC_HSIZE_WORD = 3'h2;
  localparam int unsigned AOC_TRANS_ACTIVE_POS = 1;
  localparam logic [31:0] AOC_RDATA_ZERO = 32'h0000_0000;

  // configuration and status field positions
  localparam int unsigned AOC_CFG_CONFIGURED_POS = 0;
  localparam int unsigned AOC_CFG_FORCE_ERROR_POS = 1;
  localparam int unsigned AOC_CFG_TIMEOUT_POS = 2;
  localparam int unsigned AOC_CFG_HOLD_POS = 5;
  localparam int unsigned AOC_CFG_SPARE_POS = 6;
  localparam int unsigned AOC_CFG_POWER_DISABLE_POS = 7;

  // current flag positions inside one channel pair
  localparam int unsigned AOC_FLAG_OVER_POS = 0;
  localparam int unsigned AOC_FLAG_UNDER_POS = 1;
  localparam int unsigned AOC_FLAG_STRIDE = 2;

  // timing
  localparam int unsigned AOC_CLK_PERIOD_NS = 50;
  localparam int unsigned AOC_MS_NS = 1000000;
  localparam int unsigned AOC_CYCLES_PER_MS = AOC_MS_NS / AOC_CLK_PERIOD_NS;
  localparam int unsigned AOC_PRESC_W = 16;
  localparam int unsigned AOC_MS_W = 14;
  localparam logic [AOC_MS_W-1:0] AOC_WD_SEL0_MS = 14'h3E80;
  localparam logic [AOC_MS_W-1:0] AOC_WD_SEL1_MS = 14'h0FA0;
  localparam logic [AOC_MS_W-1:0] AOC_WD_SEL2_MS = 14'h07D0;
  localparam logic [AOC_MS_W-1:0] AOC_WD_SEL3_MS = 14'h03E8;
  localparam logic [AOC_MS_W-1:0] AOC_WD_SEL4_MS = 14'h01F4;
  localparam logic [AOC_MS_W-1:0] AOC_WD_SEL5_MS = 14'h00FA;
  localparam logic [AOC_MS_W-1:0] AOC_WD_SEL6_MS = 14'h007D;
  localparam logic [AOC_MS_W-1:0] AOC_WD_SEL7_MS = 14'h003E;

  typedef enum logic [1:0] {
    AOC_VAR_VOLTAGE,
    AOC_VAR_CURRENT_DIAG,
    AOC_VAR_CURRENT_NODIAG
  } aoc_variant_type;

  typedef struct packed {
    logic powerDisable;
    logic spare;
    logic holdOutput;
    logic [2:0] timeoutSel;
    logic forceError;
    logic configured;
  } aoc_cfg_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic mapped;
    logic [3:0] idx;
  } aoc_phase_type;

  typedef struct packed {
    aoc_phase_type phase;
    aoc_cfg_type cfg;
    logic [AOC_NUM_CH-1:0][AOC_CODE_W-1:0] code;
    logic [AOC_NUM_CH-1:0][AOC_CODE_W-1:0] dacOut;
    logic [31:0] rdata;
    logic readyOut;
    logic respErr;
    logic commSeen;
    logic commLed;
    logic faultLed;
    logic [AOC_NUM_CH-1:0] chanLed;
    logic [AOC_NUM_CH-1:0] powerLost;
  } aoc_state_type;

  typedef struct packed {
    logic [AOC_PRESC_W-1:0] presc;
    logic [AOC_MS_W-1:0] msCount;
    logic expired;
  } aoc_wd_state_type;

  // power-up value: everything cleared, unconfigured
  localparam aoc_state_type AOC_STATE_RESET = '0;
  localparam aoc_wd_state_type AOC_WD_RESET = '0;

  function automatic logic [AOC_MS_W-1:0] aoc_wd_period_ms(input logic [2:0] sel);
    case (sel)
      3'h0: aoc_wd_period_ms = AOC_WD_SEL0_MS;
      3'h1: aoc_wd_period_ms = AOC_WD_SEL1_MS;
      3'h2: aoc_wd_period_ms = AOC_WD_SEL2_MS;
      3'h3: aoc_wd_period_ms = AOC_WD_SEL3_MS;
      3'h4: aoc_wd_period_ms = AOC_WD_SEL4_MS;
      3'h5: aoc_wd_period_ms = AOC_WD_SEL5_MS;
      3'h6: aoc_wd_period_ms = AOC_WD_SEL6_MS;
      default: aoc_wd_period_ms = AOC_WD_SEL7_MS;
    endcase
  endfunction : aoc_wd_period_ms

endpackage : aoc_pkg

// File: rtl/aoc_watchdog.sv
// communication watchdog with millisecond prescaler
`timescale 1ns/10ps
module aoc_watchdog #(
  parameter int unsigned CYCLES_PER_MS = aoc_pkg::AOC_CYCLES_PER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic restart,
  input wire logic [2:0] timeoutSel,
  // state
  output logic expired
);

  localparam logic [aoc_pkg::AOC_PRESC_W-1:0] PRESC_LAST =
    aoc_pkg::AOC_PRESC_W'(CYCLES_PER_MS - 1);

  aoc_pkg::aoc_wd_state_type wdReg;
  aoc_pkg::aoc_wd_state_type wdNext;
  logic [aoc_pkg::AOC_MS_W-1:0] periodMs;

  if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > (1 << aoc_pkg::AOC_PRESC_W))
  begin : g_bad_presc
    $error("prescale count out of range");
  end

  always_comb
  begin
    wdNext = wdReg;
    periodMs = aoc_pkg::aoc_wd_period_ms(timeoutSel);
    if (restart)
    begin
      // any access to a mapped register starts a fresh period and ends an expiry
      wdNext = aoc_pkg::AOC_WD_RESET;
    end
    else if (wdReg.presc == PRESC_LAST)
    begin
      // count whole milliseconds; tolerance allows the 62 ms rounding
      wdNext.presc = '0;
      if (!wdReg.expired)
      begin
        wdNext.msCount = wdReg.msCount + 1'b1;
        if (wdReg.msCount + 1'b1 >= periodMs)
        begin
          wdNext.expired = 1'b1;
        end
      end
    end
    else
    begin
      wdNext.presc = wdReg.presc + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wdReg <= aoc_pkg::AOC_WD_RESET;
    end
    else
    begin
      wdReg <= wdNext;
    end
  end

  assign expired = wdReg.expired;

  property p_restart_clears;
    @(posedge clk) disable iff (srst)
    restart |=> !expired ##1 (!expired || $past(restart, 1) == 1'b0);
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("watchdog still expired after restart");

  property p_expire_on_period;
    @(posedge clk) disable iff (srst)
    $rose(expired) |-> $past(wdReg.msCount) + 1'b1 >= $past(periodMs);
  endproperty
  a_expire_on_period: assert property (p_expire_on_period)
    else $error("watchdog expired before its period");

  property p_expired_sticks;
    @(posedge clk) disable iff (srst)
    (expired && !restart) |=> expired;
  endproperty
  a_expired_sticks: assert property (p_expired_sticks)
    else $error("expiry dropped without an access");

endmodule : aoc_watchdog

// File: rtl/aoc_ctrl.sv
// configuration, status, watchdog and indicator logic of the analog output block
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
// Function
// - address 13 writes config, reads status
// - no reads or outputs until configured
// - force error: fault lamp, data unreadable
// - status bits mirror configuration fields
// - bits 4:2 select watchdog period
// - access to 0-3,12,13 restarts watchdog
// - sixteen second period after power-up
// - all configuration bits clear at power-up
// - expiry with hold keeps outputs, comm off
// - expiry without hold zeroes outputs
// - bit 7 disables output power
// - address 12 read-only current flags
// - channel n flags at bits 2(n-1)
// - undercurrent only on current variant
// - both flags mean field power lost
// - undiagnosed current variant reads zero flags
// - fault lamp on force error or expiry
// - comm lamp on while talking, off expiry
// - channel lamps on until configured, except undiagnosed variant
// - channel lamps follow flags after configuration
// - four channels of twelve-bit codes
module aoc_ctrl #(
  parameter aoc_pkg::aoc_variant_type VARIANT = aoc_pkg::AOC_VAR_CURRENT_DIAG,
  parameter int unsigned CYCLES_PER_MS = aoc_pkg::AOC_CYCLES_PER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // field diagnostics
  input wire logic [aoc_pkg::AOC_NUM_CH-1:0] overCurrent,
  input wire logic [aoc_pkg::AOC_NUM_CH-1:0] underCurrent,
  // converter side
  output logic [aoc_pkg::AOC_NUM_CH-1:0][aoc_pkg::AOC_CODE_W-1:0] dacCode,
  output logic powerDisable,
  output logic configured,
  output logic [aoc_pkg::AOC_NUM_CH-1:0] fieldPowerLost,
  // indicators
  output logic commLed,
  output logic faultLed,
  output logic [aoc_pkg::AOC_NUM_CH-1:0] channelFaultIndicators
);

  localparam int unsigned NCH = aoc_pkg::AOC_NUM_CH;
  localparam logic DIAG = (VARIANT != aoc_pkg::AOC_VAR_CURRENT_NODIAG);
  localparam logic UNDER_OK = (VARIANT == aoc_pkg::AOC_VAR_CURRENT_DIAG);

  aoc_pkg::aoc_state_type stReg;
  aoc_pkg::aoc_state_type stNext;
  logic accept;
  logic mapped;
  logic [3:0] idx;
  logic restart;
  logic wdExpired;
  logic [7:0] flags;

  if (VARIANT > aoc_pkg::AOC_VAR_CURRENT_NODIAG)
  begin : g_bad_variant
    $error("unknown module variant");
  end

  function automatic logic is_mapped(input logic [3:0] i);
    is_mapped = (i <= aoc_pkg::AOC_IDX_CODE3) || (i == aoc_pkg::AOC_IDX_FLAGS) ||
      (i == aoc_pkg::AOC_IDX_CFG);
  endfunction : is_mapped

  function automatic logic is_code(input logic [3:0] i);
    is_code = (i >= aoc_pkg::AOC_IDX_CODE0) && (i <= aoc_pkg::AOC_IDX_CODE3);
  endfunction : is_code

  // diagnostic flag word, strapped per variant
  function automatic logic [7:0] make_flags(input logic [NCH-1:0] ov,
    input logic [NCH-1:0] un);
    logic [7:0] f;
    f = 8'h00;
    for (int n = 0; n < NCH; n++)
    begin
      f[n * aoc_pkg::AOC_FLAG_STRIDE + aoc_pkg::AOC_FLAG_OVER_POS] = DIAG && ov[n];
      f[n * aoc_pkg::AOC_FLAG_STRIDE + aoc_pkg::AOC_FLAG_UNDER_POS] = UNDER_OK && un[n];
    end
    make_flags = f;
  endfunction : make_flags

  aoc_watchdog #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_watchdog (
    .clk(clk),
    .srst(srst),
    .restart(restart),
    .timeoutSel(stReg.cfg.timeoutSel),
    .expired(wdExpired)
  );

  always_comb
  begin
    stNext = stReg;
    flags = make_flags(overCurrent, underCurrent);
    idx = haddr[5:2];
    accept = hsel && hready && htrans[aoc_pkg::AOC_TRANS_ACTIVE_POS];
    // unmapped or narrow accesses complete OKAY with no effect
    mapped = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'h0) &&
      (hsize == aoc_pkg::AOC_HSIZE_WORD) && is_mapped(idx);
    restart = accept && mapped;
    stNext.readyOut = 1'b1;
    stNext.respErr = 1'b0;

    // address phase capture
    stNext.phase.valid = accept;
    stNext.phase.write = hwrite;
    stNext.phase.mapped = mapped;
    stNext.phase.idx = idx;

    // write data phase
    if (stReg.phase.valid && stReg.phase.write && stReg.phase.mapped)
    begin
      if (stReg.phase.idx == aoc_pkg::AOC_IDX_CFG)
      begin
        // bit 0 is taken as written; a clear drops back to unconfigured
        stNext.cfg = aoc_pkg::aoc_cfg_type'(hwdata[7:0]);
        stNext.cfg.spare = 1'b0;
      end
      else if (is_code(stReg.phase.idx))
      begin
        // data writes stay open under forced error
        stNext.code[stReg.phase.idx[1:0]] = hwdata[aoc_pkg::AOC_CODE_W-1:0];
      end
      // flags index is read-only: nothing stored
    end

    // read data, presented in the following data phase
    stNext.rdata = aoc_pkg::AOC_RDATA_ZERO;
    if (accept && !hwrite && mapped && stReg.cfg.configured)
    begin
      if (idx == aoc_pkg::AOC_IDX_CFG)
      begin
        stNext.rdata[7:0] = stReg.cfg;
      end
      else if (idx == aoc_pkg::AOC_IDX_FLAGS)
      begin
        stNext.rdata[7:0] = flags;
      end
      else if (!stReg.cfg.forceError)
      begin
        stNext.rdata[aoc_pkg::AOC_CODE_W-1:0] = stReg.code[idx[1:0]];
      end
    end

    // converter outputs
    if (!stReg.cfg.configured)
    begin
      stNext.dacOut = '0;
    end
    else if (wdExpired && stReg.cfg.holdOutput)
    begin
      stNext.dacOut = stReg.dacOut;
    end
    else if (wdExpired)
    begin
      stNext.dacOut = '0;
    end
    else
    begin
      stNext.dacOut = stReg.code;
    end

    // indicators
    stNext.faultLed = stReg.cfg.forceError || wdExpired;
    stNext.commSeen = stReg.commSeen || restart;
    stNext.commLed = stReg.commSeen && !wdExpired;
    for (int n = 0; n < NCH; n++)
    begin
      stNext.powerLost[n] = DIAG && UNDER_OK && overCurrent[n] && underCurrent[n];
      if (!DIAG)
      begin
        stNext.chanLed[n] = 1'b0;
      end
      else if (!stReg.cfg.configured)
      begin
        stNext.chanLed[n] = 1'b1;
      end
      else
      begin
        // power loss shows as overcurrent too, so it lights the lamp
        stNext.chanLed[n] = overCurrent[n] || (UNDER_OK && underCurrent[n]);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stReg <= aoc_pkg::AOC_STATE_RESET;
    end
    else
    begin
      stReg <= stNext;
    end
  end

  assign hreadyout = stReg.readyOut;
  assign hresp = stReg.respErr;
  assign hrdata = stReg.rdata;
  assign dacCode = stReg.dacOut;
  assign powerDisable = stReg.cfg.powerDisable;
  assign configured = stReg.cfg.configured;
  assign fieldPowerLost = stReg.powerLost;
  assign commLed = stReg.commLed;
  assign faultLed = stReg.faultLed;
  assign channelFaultIndicators = stReg.chanLed;

  property p_cfg_write;
    @(posedge clk) disable iff (srst)
    (stReg.phase.valid && stReg.phase.write && stReg.phase.mapped &&
      stReg.phase.idx == aoc_pkg::AOC_IDX_CFG)
      |=> stReg.cfg[aoc_pkg::AOC_CFG_CONFIGURED_POS] ==
        $past(hwdata[aoc_pkg::AOC_CFG_CONFIGURED_POS]) &&
        powerDisable == $past(hwdata[aoc_pkg::AOC_CFG_POWER_DISABLE_POS]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration write not stored");

  property p_unconfigured_read;
    @(posedge clk) disable iff (srst)
    (accept && !hwrite && !stReg.cfg.configured) |=> hrdata == 32'h0000_0000;
  endproperty
  a_unconfigured_read: assert property (p_unconfigured_read)
    else $error("read answered before configuration");

  property p_forced_data_read;
    @(posedge clk) disable iff (srst)
    (accept && !hwrite && is_code(idx) && stReg.cfg.forceError) |=> hrdata == 32'h0000_0000;
  endproperty
  a_forced_data_read: assert property (p_forced_data_read)
    else $error("data read under forced error");

  property p_status_read;
    @(posedge clk) disable iff (srst)
    (accept && !hwrite && mapped && idx == aoc_pkg::AOC_IDX_CFG && stReg.cfg.configured)
      |=> hrdata[7:0] == $past(stReg.cfg) && !hrdata[aoc_pkg::AOC_CFG_SPARE_POS];
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read mismatch");

  property p_flags_read;
    @(posedge clk) disable iff (srst)
    (accept && !hwrite && mapped && idx == aoc_pkg::AOC_IDX_FLAGS && stReg.cfg.configured)
      |=> hrdata[7:0] == $past(flags);
  endproperty
  a_flags_read: assert property (p_flags_read)
    else $error("flag read mismatch");

  property p_hold_on_expiry;
    @(posedge clk) disable iff (srst)
    (wdExpired && stReg.cfg.holdOutput && stReg.cfg.configured) |=> $stable(dacCode);
  endproperty
  a_hold_on_expiry: assert property (p_hold_on_expiry)
    else $error("outputs moved during held expiry");

  property p_zero_on_expiry;
    @(posedge clk) disable iff (srst)
    (wdExpired && !stReg.cfg.holdOutput) |=> dacCode == '0;
  endproperty
  a_zero_on_expiry: assert property (p_zero_on_expiry)
    else $error("outputs not zeroed on expiry");

  property p_fault_lamp;
    @(posedge clk) disable iff (srst)
    (stReg.cfg.forceError || wdExpired) |=> faultLed;
  endproperty
  a_fault_lamp: assert property (p_fault_lamp)
    else $error("fault lamp dark");

  property p_comm_lamp_off;
    @(posedge clk) disable iff (srst)
    wdExpired |=> !commLed;
  endproperty
  a_comm_lamp_off: assert property (p_comm_lamp_off)
    else $error("comm lamp lit after expiry");

  property p_lamps_unconfigured;
    @(posedge clk) disable iff (srst)
    (DIAG && !stReg.cfg.configured) |=> channelFaultIndicators == '1;
  endproperty
  a_lamps_unconfigured: assert property (p_lamps_unconfigured)
    else $error("channel lamps dark before configuration");

  property p_nodiag_flags;
    @(posedge clk) disable iff (srst)
    !DIAG |-> flags == 8'h00 && channelFaultIndicators == '0;
  endproperty
  a_nodiag_flags: assert property (p_nodiag_flags)
    else $error("undiagnosed variant shows flags");

  property p_power_loss;
    @(posedge clk) disable iff (srst)
    (UNDER_OK && overCurrent[0] && underCurrent[0]) |=> fieldPowerLost[0];
  endproperty
  a_power_loss: assert property (p_power_loss)
    else $error("field power loss missed");

  // odd bits of the flag word carry undercurrent
  property p_voltage_no_under;
    @(posedge clk) disable iff (srst)
    (VARIANT == aoc_pkg::AOC_VAR_VOLTAGE) |-> (flags & 8'hAA) == 8'h00;
  endproperty
  a_voltage_no_under: assert property (p_voltage_no_under)
    else $error("undercurrent flag on voltage variant");

  property p_chan_lamp_over;
    @(posedge clk) disable iff (srst)
    (DIAG && stReg.cfg.configured && overCurrent[0]) |=> channelFaultIndicators[0];
  endproperty
  a_chan_lamp_over: assert property (p_chan_lamp_over)
    else $error("channel lamp dark on overcurrent");

  property p_comm_lamp_relit;
    @(posedge clk) disable iff (srst)
    (stReg.commSeen && !wdExpired) |=> commLed;
  endproperty
  a_comm_lamp_relit: assert property (p_comm_lamp_relit)
    else $error("comm lamp dark while talking");

endmodule : aoc_ctrl

// File: tb/aoc_bus_master.sv
// bus master model of the controller side, single word transfers
`timescale 1ns/10ps
module aoc_bus_master (
  // clock
  input wire logic clk,
  // bus answer
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = aoc_pkg::AOC_HSIZE_WORD;
    hwdata = 32'h0000_0000;
  end

  // called just after a rising edge; returns at the edge that takes the data
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= aoc_pkg::AOC_HSIZE_WORD;
    // stale write data is scrambled so it never passes as the new value
    hwdata <= ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : aoc_bus_master

// File: tb/analog_output_ctrl_status_tb_top.sv
// self-checking testbench of the analog output control block
`timescale 1ns/10ps
module analog_output_ctrl_status_tb_top;
  logic clk;
  logic srst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] overCurrent;
  logic [3:0] underCurrent;
  logic [3:0][11:0] dacCode;
  logic powerDisable;
  logic configured;
  logic [3:0] fieldPowerLost;
  logic commLed;
  logic faultLed;
  logic [3:0] chanInd;
  logic [31:0] voltRdata;
  logic [3:0] voltChanInd;
  logic [3:0] voltPowerLost;
  logic [31:0] noDiagRdata;
  logic [3:0] noDiagChanInd;
  logic [3:0] noDiagPowerLost;
  int nMismatch = 0;
  int totalChecks = 0;

  // short millisecond keeps the 62 ms period at 248 cycles
  aoc_ctrl #(.VARIANT(aoc_pkg::AOC_VAR_CURRENT_DIAG), .CYCLES_PER_MS(4)) dut (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .overCurrent(overCurrent), .underCurrent(underCurrent), .dacCode(dacCode),
    .powerDisable(powerDisable), .configured(configured),
    .fieldPowerLost(fieldPowerLost), .commLed(commLed), .faultLed(faultLed),
    .channelFaultIndicators(chanInd));

  // other variants see the same traffic and field flags
  aoc_ctrl #(.VARIANT(aoc_pkg::AOC_VAR_VOLTAGE), .CYCLES_PER_MS(4)) dutVolt (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(), .hresp(), .hrdata(voltRdata),
    .overCurrent(overCurrent), .underCurrent(underCurrent), .dacCode(),
    .powerDisable(), .configured(), .fieldPowerLost(voltPowerLost), .commLed(),
    .faultLed(), .channelFaultIndicators(voltChanInd));

  aoc_ctrl #(.VARIANT(aoc_pkg::AOC_VAR_CURRENT_NODIAG), .CYCLES_PER_MS(4)) dutNoDiag (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(), .hresp(), .hrdata(noDiagRdata),
    .overCurrent(overCurrent), .underCurrent(underCurrent), .dacCode(),
    .powerDisable(), .configured(), .fieldPowerLost(noDiagPowerLost), .commLed(),
    .faultLed(), .channelFaultIndicators(noDiagChanInd));

  aoc_bus_master master (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : giveVerdict

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    master.xfer(1'b1, a, d, unused);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] got;
    master.xfer(1'b0, a, 32'h0000_0000, got);
    check(got, exp);
  endtask : rd

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
  endtask : waitCyc

  initial
  begin
    waitCyc(5000);
    nMismatch++;
    giveVerdict();
  end

  initial
  begin
    srst = 1'b1;
    overCurrent = 4'h0;
    underCurrent = 4'h0;
    waitCyc(16);
    srst <= 1'b0;
    waitCyc(2);
    check({31'h0, hreadyout}, 32'h0000_0001);
    check({28'h0, chanInd}, 32'h0000_000F);
    check({24'h0, voltChanInd, noDiagChanInd}, 32'h0000_00F0);
    rd(32'h0000_0034, 32'h0000_0000);
    overCurrent <= 4'h5;
    underCurrent <= 4'h4;
    wr(32'h0000_0000, 32'h0000_0ABC);
    waitCyc(3);
    check({20'h0, dacCode[0]}, 32'h0000_0000);
    check({31'h0, faultLed}, 32'h0000_0000);
    // bit 6 is written high but never stored
    wr(32'h0000_0034, 32'h0000_00E1);
    waitCyc(3);
    rd(32'h0000_0034, 32'h0000_00A1);
    check({31'h0, powerDisable}, 32'h0000_0001);
    check({31'h0, configured}, 32'h0000_0001);
    check({31'h0, hresp}, 32'h0000_0000);
    rd(32'h0000_0000, 32'h0000_0ABC);
    check({20'h0, dacCode[0]}, 32'h0000_0ABC);
    rd(32'h0000_0030, 32'h0000_0031);
    // side instances answer in the same data phase
    check(voltRdata, 32'h0000_0011);
    check(noDiagRdata, 32'h0000_0000);
    wr(32'h0000_0030, 32'h0000_00FF);
    rd(32'h0000_0030, 32'h0000_0031);
    check({28'h0, fieldPowerLost}, 32'h0000_0004);
    check({28'h0, chanInd}, 32'h0000_0005);
    check({24'h0, voltChanInd, voltPowerLost}, 32'h0000_0050);
    check({24'h0, noDiagChanInd, noDiagPowerLost}, 32'h0000_0000);
    rd(32'h0000_0040, 32'h0000_0000);
    // forced error: data writable but not readable
    wr(32'h0000_0034, 32'h0000_0003);
    waitCyc(3);
    check({31'h0, faultLed}, 32'h0000_0001);
    rd(32'h0000_0000, 32'h0000_0000);
    wr(32'h0000_0004, 32'h0000_0123);
    wr(32'h0000_0034, 32'h0000_0001);
    rd(32'h0000_0004, 32'h0000_0123);
    waitCyc(3);
    check({31'h0, faultLed}, 32'h0000_0000);
    // shortest period with hold; mid-way access restarts the count
    wr(32'h0000_0034, 32'h0000_003D);
    waitCyc(200);
    rd(32'h0000_0004, 32'h0000_0123);
    waitCyc(240);
    check({30'h0, commLed, faultLed}, 32'h0000_0002);
    waitCyc(15);
    check({30'h0, commLed, faultLed}, 32'h0000_0001);
    check({20'h0, dacCode[0]}, 32'h0000_0ABC);
    rd(32'h0000_0034, 32'h0000_003D);
    waitCyc(3);
    check({30'h0, commLed, faultLed}, 32'h0000_0002);
    // expiry without hold zeroes every output
    wr(32'h0000_0034, 32'h0000_001D);
    waitCyc(260);
    check({31'h0, faultLed}, 32'h0000_0001);
    check({20'h0, dacCode[0] | dacCode[1] | dacCode[2] | dacCode[3]}, 32'h0000_0000);
    giveVerdict();
  end
endmodule : analog_output_ctrl_status_tb_top
